/* hw/operator_panel_trap_control.sv */
// operator panel, error traps and real-time clock steal for the processor
//
// What this block does
// RULE1: fault lamp sets on top-six-zero instruction
// RULE2: fault lamp holds until its button pressed
// RULE3: bad core read parity latches parity lamp
// RULE4: program flag instruction sets flag lamp
// RULE5: accumulator buttons set bits; clear zeroes all
// RULE6: location buttons set bits; clear zeroes all
// RULE7: manual interrupt runs location 00023 in trap
// RULE8: master clear zeroes registers, not core
// RULE9: bootstrap armed after master clear, starts on run
// RULE10: run starts at held instruction location
// RULE11: stop waits for instruction to finish
// RULE12: switch test skips when addressed switch on
// RULE13: switch 15 picks halt or trap 00020
// RULE14: switch 14 picks halt or trap 00021
// RULE15: switch 13 picks halt or trap 00022
// RULE16: switch 12 bumps word 00024 every 5 ms
// RULE17: each clock bump steals 6 us
// RULE18: panel controls act even while running
// RULE19: each press gives exactly one pulse
`timescale 1ns/1ps
module operator_panel_trap_control
   import panel_pkg::*;
#(
   parameter int RTC_PERIOD = RTC_PERIOD_CYC,
   parameter int RTC_STEAL = RTC_STEAL_CYC
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // operator panel
   input wire panel_btn_t btn_in,
   input wire logic [SW_N-1:0] sw_in,
   // processor control unit
   input wire cpu_evt_t cpu,
   // register displays and lamps
   output logic [ACC_W-1:0] acc_out,
   output logic [ILOC_W-1:0] iloc_out,
   output lamps_t lamps_out,
   output logic running,
   // run control
   output logic run_start,
   output logic boot_start,
   output logic [CHAN_W-1:0] boot_chan,
   output logic skip,
   // traps
   output logic trap_req,
   output logic [ADDR_W-1:0] trap_addr,
   // real-time clock steal
   output logic rtc_pulse,
   output logic rtc_busy
);

   typedef struct packed
   {
      panel_btn_t b1;
      panel_btn_t b2;
      panel_btn_t b3;
      panel_btn_t bdeb;
      logic [SW_N-1:0] s1;
      logic [SW_N-1:0] s2;
      logic [SW_N-1:0] s3;
      logic [SW_N-1:0] sdeb;
      logic [ACC_W-1:0] acc;
      logic [ILOC_W-1:0] iloc;
      lamps_t lamps;
      run_state_t state;
      logic running;
      logic [PEND_N-1:0] pend;
      logic trap_req;
      logic [ADDR_W-1:0] trap_addr;
      logic skip;
      logic mc_seen;
      logic boot_armed;
      logic boot_start;
      logic [CHAN_W-1:0] boot_chan;
      logic run_start;
      logic [RTC_CNT_W-1:0] rtc_cnt;
      logic rtc_pulse;
      logic rtc_busy;
      logic [STEAL_CNT_W-1:0] steal_cnt;
   } state_t;

   localparam state_t ST_RST = '{state: ST_HALT, default: '0};

   state_t st_r;
   state_t st_nxt;
   panel_btn_t btn_deb;
   panel_btn_t press;
   logic [SW_N-1:0] sw_deb;
   logic bad_op_ev;
   logic io_chk_ev;
   logic prog_chk_ev;
   logic bad_opcode_response_select;
   logic io_read_check_response_select;
   logic program_read_check_response_select;

   // level accepted once the second and third stages agree
   assign btn_deb = (st_r.b2 & st_r.b3) | (st_r.bdeb & (st_r.b2 | st_r.b3));
   assign sw_deb = (st_r.s2 & st_r.s3) | (st_r.sdeb & (st_r.s2 | st_r.s3));
   // one pulse per press on the rising accepted level
   assign press = btn_deb & ~st_r.bdeb; // RULE19

   assign bad_op_ev = cpu.instr_valid
      && (cpu.instr_word[ACC_W-1 -: BAD_OP_ZERO_BITS] == '0); // RULE1
   assign io_chk_ev = cpu.read_done && cpu.read_bad && cpu.read_for_io;
   assign prog_chk_ev = cpu.read_done && cpu.read_bad && !cpu.read_for_io;
   assign bad_opcode_response_select = st_r.sdeb[SW_BAD_OP];
   assign io_read_check_response_select = st_r.sdeb[SW_IO_CHK];
   assign program_read_check_response_select = st_r.sdeb[SW_PROG_CHK];

   always_comb
   begin
      logic [PEND_N-1:0] pend_set;
      logic [PEND_N-1:0] pend_clr;
      logic halt_ev;
      int sel;
      pend_set = '0;
      pend_clr = '0;
      halt_ev = 1'b0;
      sel = 0;
      st_nxt = st_r;
      // three-stage synchronisers
      st_nxt.b1 = btn_in;
      st_nxt.b2 = st_r.b1;
      st_nxt.b3 = st_r.b2;
      st_nxt.bdeb = btn_deb;
      st_nxt.s1 = sw_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.sdeb = sw_deb;
      st_nxt.skip = 1'b0;
      st_nxt.boot_start = 1'b0;
      st_nxt.run_start = 1'b0;
      st_nxt.rtc_pulse = 1'b0;

      // lamps: a new event wins over a press in the same cycle
      st_nxt.lamps.fault = (st_r.lamps.fault & ~press.fault_clr) | bad_op_ev; // RULE2
      st_nxt.lamps.parity = (st_r.lamps.parity & ~press.parity_clr)
         | (cpu.read_done & cpu.read_bad); // RULE3
      st_nxt.lamps.flag = (st_r.lamps.flag & ~press.flag_clr)
         | (cpu.instr_valid & cpu.program_flag_instruction); // RULE4

      // displayed registers, buttons act in any run state
      if (cpu.acc_load)
         st_nxt.acc = cpu.acc_data;
      st_nxt.acc = st_nxt.acc | press.acc_set; // RULE5 RULE18
      if (press.acc_clr)
         st_nxt.acc = ACC_RST; // RULE5
      if (cpu.iloc_load)
         st_nxt.iloc = cpu.iloc_data;
      st_nxt.iloc = st_nxt.iloc | press.iloc_set; // RULE6 RULE18
      if (press.iloc_clr)
         st_nxt.iloc = ILOC_RST; // RULE6

      // sense switch test
      if (cpu.instr_valid && cpu.switch_test_skip_instruction)
         st_nxt.skip = st_r.sdeb[cpu.test_sw]; // RULE12

      // error reactions: trap when switch up, halt when down
      pend_set[PEND_BAD] = bad_op_ev & bad_opcode_response_select; // RULE13
      pend_set[PEND_IO] = io_chk_ev & io_read_check_response_select; // RULE14
      pend_set[PEND_PROG] = prog_chk_ev & program_read_check_response_select; // RULE15
      pend_set[PEND_MAN] = press.manual_int; // RULE7
      halt_ev = (bad_op_ev & ~bad_opcode_response_select) // RULE13
         | (io_chk_ev & ~io_read_check_response_select) // RULE14
         | (prog_chk_ev & ~program_read_check_response_select); // RULE15

      // trap issue, only while running; a stopped request waits
      if (st_r.trap_req)
      begin
         if (cpu.trap_ack)
            st_nxt.trap_req = 1'b0;
      end
      else if (st_r.state != ST_HALT && st_r.pend != '0)
      begin
         for (int i = PEND_N - 1; i >= 0; i--)
         begin
            if (st_r.pend[i])
               sel = i;
         end
         pend_clr[sel] = 1'b1;
         st_nxt.trap_req = 1'b1; // RULE7
         st_nxt.trap_addr = VEC_BASE + ADDR_W'(sel); // RULE13 RULE14 RULE15
      end
      st_nxt.pend = (st_r.pend & ~pend_clr) | pend_set;

      // run control
      case (st_r.state)
         ST_HALT:
         begin
            if (press.run)
            begin
               st_nxt.state = ST_RUN; // RULE10
               st_nxt.run_start = 1'b1; // RULE10
               st_nxt.mc_seen = 1'b0;
               if (st_r.boot_armed)
               begin
                  st_nxt.boot_start = 1'b1; // RULE9
                  st_nxt.boot_chan = BOOT_CHANNEL; // RULE9
                  st_nxt.boot_armed = 1'b0;
               end
            end
            else if (press.boot && st_r.mc_seen)
               st_nxt.boot_armed = 1'b1; // RULE9
         end
         ST_RUN:
         begin
            if (press.stop || halt_ev)
               st_nxt.state = cpu.instr_done ? ST_HALT : ST_STOP; // RULE11
         end
         ST_STOP:
         begin
            if (cpu.instr_done)
               st_nxt.state = ST_HALT; // RULE11
            else if (press.run && !halt_ev)
               st_nxt.state = ST_RUN;
         end
         default:
            st_nxt.state = ST_HALT;
      endcase

      // real-time clock interval and memory steal
      if (st_r.sdeb[SW_RTC])
      begin
         if (st_r.rtc_cnt == RTC_CNT_W'(RTC_PERIOD - 1))
         begin
            st_nxt.rtc_cnt = '0;
            st_nxt.rtc_pulse = 1'b1; // RULE16
            st_nxt.rtc_busy = 1'b1; // RULE17
            st_nxt.steal_cnt = STEAL_CNT_W'(RTC_STEAL - 1); // RULE17
         end
         else
            st_nxt.rtc_cnt = st_r.rtc_cnt + 1'b1; // RULE16
      end
      else
         st_nxt.rtc_cnt = '0; // RULE16
      if (st_r.rtc_busy)
      begin
         if (st_r.steal_cnt == '0)
            st_nxt.rtc_busy = 1'b0; // RULE17
         else
            st_nxt.steal_cnt = st_r.steal_cnt - 1'b1;
      end

      // master clear overrides everything but the synchronisers and boot_chan
      if (press.master_clear)
      begin
         st_nxt.acc = ACC_RST; // RULE8
         st_nxt.iloc = ILOC_RST; // RULE8
         st_nxt.lamps = '0;
         st_nxt.pend = '0;
         st_nxt.state = ST_HALT; // RULE8
         st_nxt.trap_req = 1'b0;
         st_nxt.trap_addr = '0;
         st_nxt.skip = 1'b0;
         st_nxt.run_start = 1'b0;
         st_nxt.boot_start = 1'b0;
         st_nxt.boot_armed = 1'b0;
         st_nxt.mc_seen = 1'b1; // RULE9
         st_nxt.rtc_cnt = '0;
         st_nxt.rtc_pulse = 1'b0;
         st_nxt.rtc_busy = 1'b0;
         st_nxt.steal_cnt = '0;
      end
      st_nxt.running = (st_nxt.state != ST_HALT);
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         st_r <= ST_RST;
      else
         st_r <= st_nxt;
   end

   assign acc_out = st_r.acc;
   assign iloc_out = st_r.iloc;
   assign lamps_out = st_r.lamps;
   assign running = st_r.running;
   assign run_start = st_r.run_start;
   assign boot_start = st_r.boot_start;
   assign boot_chan = st_r.boot_chan;
   assign skip = st_r.skip;
   assign trap_req = st_r.trap_req;
   assign trap_addr = st_r.trap_addr;
   assign rtc_pulse = st_r.rtc_pulse;
   assign rtc_busy = st_r.rtc_busy;

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   a_fault_lamp_set: assert property (bad_op_ev && !press.master_clear |=> lamps_out.fault) // RULE1
      else $error("fault lamp not set by bad opcode");
   a_fault_lamp_hold: assert property (lamps_out.fault && !press.fault_clr // RULE2
      && !press.master_clear |=> lamps_out.fault)
      else $error("fault lamp dropped without press");
   a_parity_lamp_set: assert property (cpu.read_done && cpu.read_bad // RULE3
      && !press.master_clear |=> lamps_out.parity)
      else $error("parity lamp not set");
   a_flag_lamp_set: assert property (cpu.instr_valid && cpu.program_flag_instruction // RULE4
      && !press.master_clear |=> lamps_out.flag)
      else $error("program flag lamp not set");
   a_acc_bit_set: assert property (!cpu.acc_load && !press.acc_clr // RULE5
      && !press.master_clear |=> acc_out == ($past(acc_out) | $past(press.acc_set)))
      else $error("accumulator button set wrong");
   a_acc_clear: assert property (press.acc_clr |=> acc_out == ACC_RST) // RULE5
      else $error("accumulator not cleared");
   a_iloc_clear: assert property (press.iloc_clr |=> iloc_out == ILOC_RST) // RULE6
      else $error("location register not cleared");
   a_trap_when_run: assert property ($rose(trap_req) |-> $past(running)) // RULE7
      else $error("trap raised while halted");
   a_manual_vector: assert property (!trap_req && running && st_r.pend == 4'h8 // RULE7
      && !press.master_clear |=> trap_req && trap_addr == VEC_BASE + 15'h0003)
      else $error("manual trap vector wrong");
   a_mclr_zero: assert property (press.master_clear |=> acc_out == ACC_RST // RULE8
      && iloc_out == ILOC_RST && !running && !trap_req)
      else $error("master clear incomplete");
   a_boot_start: assert property (boot_start |-> running && $past(st_r.boot_armed)) // RULE9
      else $error("boot started unarmed");
   a_run_start: assert property (run_start |-> running ##1 !run_start) // RULE10
      else $error("run start not single pulse");
   a_stop_boundary: assert property (running && !cpu.instr_done // RULE11
      && !press.master_clear |=> running)
      else $error("stopped mid instruction");
   a_skip_value: assert property (cpu.instr_valid && cpu.switch_test_skip_instruction // RULE12
      && !press.master_clear |=> skip == $past(st_r.sdeb[cpu.test_sw]))
      else $error("switch test skip wrong");
   a_bad_op_halt: assert property (st_r.state == ST_RUN && bad_op_ev // RULE13
      && !bad_opcode_response_select && !press.master_clear
      |=> st_r.state == ST_STOP || st_r.state == ST_HALT)
      else $error("no halt on bad opcode");
   a_io_chk_trap: assert property (io_chk_ev && io_read_check_response_select // RULE14
      && !press.master_clear |=> st_r.pend[PEND_IO] || trap_addr == VEC_BASE + 15'h0001)
      else $error("io check trap lost");
   a_prog_chk_halt: assert property (st_r.state == ST_RUN && prog_chk_ev // RULE15
      && !program_read_check_response_select && !press.master_clear |=> st_r.state != ST_RUN)
      else $error("no halt on program check");
   a_rtc_off: assert property (!st_r.sdeb[SW_RTC] |=> !rtc_pulse) // RULE16
      else $error("clock bumped with switch off");
   a_rtc_steal: assert property (rtc_pulse && !press.master_clear // RULE17
      |-> rtc_busy ##1 rtc_busy)
      else $error("clock steal too short");
   a_btn_one_pulse: assert property (press.run |=> !press.run) // RULE19
      else $error("press gave two pulses");

   c_manual_trap: cover property (trap_req && trap_addr == VEC_BASE + 15'h0003);
   c_boot_run: cover property (boot_start);
   c_rtc_bump: cover property (rtc_pulse);
   c_stop_done: cover property (st_r.state == ST_STOP ##1 st_r.state == ST_HALT);

endmodule : operator_panel_trap_control

/* hw/panel_pkg.sv */
// constants and carrier types for the operator panel and trap control block
package panel_pkg;
   // widths
   localparam int ACC_W = 24;
   localparam int ILOC_W = 14;
   localparam int ADDR_W = 15;
   localparam int SW_N = 16;
   localparam int SW_SEL_W = 4;
   localparam int CHAN_W = 4;
   // an executed word whose top six bits are all zero is a bad opcode
   localparam int BAD_OP_ZERO_BITS = 6;
   // sense switch positions
   localparam int SW_BAD_OP = 15;
   localparam int SW_IO_CHK = 14;
   localparam int SW_PROG_CHK = 13;
   localparam int SW_RTC = 12;
   // trap sources, in priority order; vector is VEC_BASE plus the index
   localparam int PEND_BAD = 0;
   localparam int PEND_IO = 1;
   localparam int PEND_PROG = 2;
   localparam int PEND_MAN = 3;
   localparam int PEND_N = 4;
   // core location 00020 octal; 00021, 00022, 00023 follow
   localparam logic [ADDR_W-1:0] VEC_BASE = 15'h0010;
   // core location 00024 octal, the real-time clock word
   localparam logic [ADDR_W-1:0] RTC_WORD_ADDR = 15'h0014;
   localparam logic [CHAN_W-1:0] BOOT_CHANNEL = 4'h0;
   // reset values
   localparam logic [ACC_W-1:0] ACC_RST = 24'h000000;
   localparam logic [ILOC_W-1:0] ILOC_RST = 14'h0000;
   // timing
   localparam int CLK_MHZ = 250;
   localparam int RTC_PERIOD_US = 5000;
   localparam int RTC_STEAL_US = 6;
   localparam int RTC_PERIOD_CYC = RTC_PERIOD_US * CLK_MHZ;
   localparam int RTC_STEAL_CYC = RTC_STEAL_US * CLK_MHZ;
   localparam int RTC_CNT_W = 21;
   localparam int STEAL_CNT_W = 11;

   typedef enum logic [2:0]
   {
      ST_HALT = 3'h1,
      ST_RUN = 3'h2,
      ST_STOP = 3'h4
   } run_state_t;

   // panel pushbuttons, raw from the pins
   typedef struct packed
   {
      logic [ACC_W-1:0] acc_set;
      logic acc_clr;
      logic [ILOC_W-1:0] iloc_set;
      logic iloc_clr;
      logic fault_clr;
      logic parity_clr;
      logic flag_clr;
      logic run;
      logic stop;
      logic master_clear;
      logic boot;
      logic manual_int;
   } panel_btn_t;

   // events and loads from the processor control unit
   typedef struct packed
   {
      logic instr_valid;
      logic [ACC_W-1:0] instr_word;
      logic program_flag_instruction;
      logic switch_test_skip_instruction;
      logic [SW_SEL_W-1:0] test_sw;
      logic instr_done;
      logic read_done;
      logic read_bad;
      logic read_for_io;
      logic acc_load;
      logic [ACC_W-1:0] acc_data;
      logic iloc_load;
      logic [ILOC_W-1:0] iloc_data;
      logic trap_ack;
   } cpu_evt_t;

   typedef struct packed
   {
      logic fault;
      logic parity;
      logic flag;
   } lamps_t;
endpackage : panel_pkg

/* testbench/cpu_model.sv */
// partner model of the processor control unit facing the panel block
`timescale 1ns/1ps
module cpu_model
   import panel_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // trap handshake
   input wire logic trap_req,
   // events toward the block
   output cpu_evt_t cpu
);
   int ack_delay = 2;
   int cnt = 0;
   logic ack_r = 1'b0;
   logic done_r = 1'b0;
   cpu_evt_t evt_r = '0;
   always_comb
   begin
      cpu = evt_r;
      cpu.trap_ack = ack_r;
   end
   // one acknowledge per trap request, ack_delay plus one cycles after it rises
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ack_r <= 1'b0;
         done_r <= 1'b0;
         cnt <= 0;
      end
      else if (ack_r)
      begin
         ack_r <= 1'b0;
         done_r <= 1'b1;
      end
      else if (!trap_req)
      begin
         done_r <= 1'b0;
         cnt <= 0;
      end
      else if (!done_r)
      begin
         if (cnt >= ack_delay)
            ack_r <= 1'b1;
         else
            cnt <= cnt + 1;
      end
   end
   // one-cycle event pulse
   task issue(input cpu_evt_t e);
      @(posedge mclk);
      evt_r <= e;
      @(posedge mclk);
      evt_r <= '0;
   endtask : issue
endmodule : cpu_model

/* testbench/test_operator_panel_trap_control.sv */
// self-checking bench for the operator panel and trap control block
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin mismatches++; \
   $display("[ERR] %s expected %0h seen %0h", what, exp, got); end end
module test_operator_panel_trap_control;
   import panel_pkg::*;
   localparam int PER = 50;
   localparam int STL = 4;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   panel_btn_t btn = '0;
   logic [SW_N-1:0] sw = '0;
   cpu_evt_t cpu;
   logic [ACC_W-1:0] acc_out;
   logic [ILOC_W-1:0] iloc_out;
   lamps_t lamps_out;
   logic running, run_start, boot_start, skip, trap_req, rtc_pulse, rtc_busy;
   logic [CHAN_W-1:0] boot_chan;
   logic [ADDR_W-1:0] trap_addr;
   int mismatches = 0;
   int checks = 0;
   int run_cnt, boot_cnt;
   panel_btn_t pb;
   cpu_evt_t ev;
   always #2 mclk = ~mclk;
   operator_panel_trap_control #(.RTC_PERIOD(PER), .RTC_STEAL(STL))
      operator_panel_trap_control_inst (.mclk(mclk), .reset_n(reset_n), .btn_in(btn),
      .sw_in(sw), .cpu(cpu), .acc_out(acc_out), .iloc_out(iloc_out), .lamps_out(lamps_out),
      .running(running), .run_start(run_start), .boot_start(boot_start),
      .boot_chan(boot_chan), .skip(skip), .trap_req(trap_req), .trap_addr(trap_addr),
      .rtc_pulse(rtc_pulse), .rtc_busy(rtc_busy));
   cpu_model cpu_model_inst (.mclk(mclk), .reset_n(reset_n), .trap_req(trap_req), .cpu(cpu));
   task results;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results
   // hold a button pattern six cycles, then release; counts run pulses
   task press(input panel_btn_t b);
      run_cnt = 0;
      boot_cnt = 0;
      @(posedge mclk);
      btn <= b;
      for (int i = 0; i < 10; i++)
      begin
         @(posedge mclk);
         if (i == 5)
            btn <= '0;
         #1;
         if (run_start === 1'b1)
            run_cnt++;
         if (run_start === 1'b1 && boot_start === 1'b1)
            boot_cnt++;
      end
   endtask : press
   task set_sw(input logic [SW_N-1:0] v);
      @(posedge mclk);
      sw <= v;
      repeat (5) @(posedge mclk);
   endtask : set_sw
   task wait_trap(input logic [ADDR_W-1:0] addr);
      logic seen;
      logic [ADDR_W-1:0] got;
      seen = 1'b0;
      got = '0;
      for (int i = 0; i < 40 && !seen; i++)
      begin
         @(posedge mclk);
         #1;
         if (trap_req === 1'b1)
         begin
            seen = 1'b1;
            got = trap_addr;
         end
      end
      `CHK("trap_req", 1'b1, seen)
      `CHK("trap_addr", addr, got)
      for (int i = 0; i < 40 && trap_req !== 1'b0; i++)
         @(posedge mclk);
      #1;
      `CHK("trap_req drop", 1'b0, trap_req)
   endtask : wait_trap
   task t_acc;
      pb = '0;
      pb.acc_set = 24'h800008;
      press(pb);
      `CHK("acc set", 24'h800008, acc_out)
      ev = '0;
      ev.acc_load = 1'b1;
      ev.acc_data = 24'h000100;
      cpu_model_inst.issue(ev);
      #1;
      `CHK("acc load", 24'h000100, acc_out)
      pb = '0;
      pb.acc_clr = 1'b1;
      press(pb);
      `CHK("acc clear", 24'h000000, acc_out)
      $display("test acc done");
   endtask : t_acc
   task t_iloc_run;
      pb = '0;
      pb.iloc_set = 14'h2001;
      press(pb);
      `CHK("iloc set", 14'h2001, iloc_out)
      pb = '0;
      pb.iloc_clr = 1'b1;
      press(pb);
      `CHK("iloc clear", 14'h0000, iloc_out)
      pb = '0;
      pb.iloc_set = 14'h0005;
      press(pb);
      pb = '0;
      pb.run = 1'b1;
      press(pb);
      `CHK("run pulses", 1, run_cnt)
      `CHK("running", 1'b1, running)
      `CHK("iloc kept", 14'h0005, iloc_out)
      pb = '0;
      pb.acc_set = 24'h000002;
      press(pb);
      `CHK("acc while running", 24'h000002, acc_out)
      $display("test iloc_run done");
   endtask : t_iloc_run
   task t_traps;
      set_sw(16'hE000);
      for (int k = 0; k < 3; k++)
      begin
         ev = '0;
         ev.instr_valid = (k == 0);
         ev.instr_word = 24'h03FFFF;
         ev.read_done = (k != 0);
         ev.read_bad = (k != 0);
         ev.read_for_io = (k == 1);
         cpu_model_inst.issue(ev);
         #1;
         `CHK("fault lamp", 1'b1, lamps_out.fault)
         `CHK("parity lamp", (k != 0), lamps_out.parity)
         wait_trap(VEC_BASE + ADDR_W'(k));
         `CHK("still running", 1'b1, running)
      end
      pb = '0;
      pb.fault_clr = 1'b1;
      pb.parity_clr = 1'b1;
      press(pb);
      `CHK("lamps cleared", 3'h0, lamps_out)
      ev = '0;
      ev.instr_valid = 1'b1;
      ev.instr_word = 24'h040000;
      cpu_model_inst.issue(ev);
      #1;
      `CHK("no fault", 1'b0, lamps_out.fault)
      $display("test traps done");
   endtask : t_traps
   task t_flag_skip;
      set_sw(16'h0020);
      ev = '0;
      ev.instr_valid = 1'b1;
      ev.instr_word = 24'hFC0000;
      ev.program_flag_instruction = 1'b1;
      cpu_model_inst.issue(ev);
      #1;
      `CHK("flag lamp", 1'b1, lamps_out.flag)
      ev.program_flag_instruction = 1'b0;
      ev.switch_test_skip_instruction = 1'b1;
      for (int s = 5; s >= 4; s--)
      begin
         ev.test_sw = SW_SEL_W'(s);
         cpu_model_inst.issue(ev);
         #1;
         `CHK("skip", (s == 5), skip)
      end
      `CHK("flag held", 1'b1, lamps_out.flag)
      pb = '0;
      pb.flag_clr = 1'b1;
      press(pb);
      `CHK("flag cleared", 1'b0, lamps_out.flag)
      $display("test flag_skip done");
   endtask : t_flag_skip
   task finish_instr;
      ev = '0;
      ev.instr_done = 1'b1;
      cpu_model_inst.issue(ev);
      @(posedge mclk);
      #1;
   endtask : finish_instr
   task t_fault_halt;
      set_sw(16'h0000);
      ev = '0;
      ev.instr_valid = 1'b1;
      cpu_model_inst.issue(ev);
      repeat (3) @(posedge mclk);
      #1;
      `CHK("fault lamp", 1'b1, lamps_out.fault)
      `CHK("stopping", 1'b1, running)
      finish_instr();
      `CHK("halted", 1'b0, running)
      `CHK("no trap", 1'b0, trap_req)
      pb = '0;
      pb.fault_clr = 1'b1;
      press(pb);
      $display("test fault_halt done");
   endtask : t_fault_halt
   task t_manual;
      cpu_model_inst.ack_delay = 20;
      pb = '0;
      pb.manual_int = 1'b1;
      press(pb);
      `CHK("trap while halted", 1'b0, trap_req)
      pb = '0;
      pb.run = 1'b1;
      press(pb);
      wait_trap(VEC_BASE + 15'h0003);
      for (int k = 0; k < 2; k++)
      begin
         ev = '0;
         ev.read_done = 1'b1;
         ev.read_bad = 1'b1;
         ev.read_for_io = (k == 1);
         cpu_model_inst.issue(ev);
         #1;
         `CHK("check stopping", 1'b1, running)
         finish_instr();
         `CHK("check halted", 1'b0, running)
         pb = '0;
         pb.run = 1'b1;
         press(pb);
      end
      $display("test manual done");
   endtask : t_manual
   task t_stop;
      pb = '0;
      pb.stop = 1'b1;
      press(pb);
      `CHK("stop waits", 1'b1, running)
      finish_instr();
      `CHK("stopped", 1'b0, running)
      $display("test stop done");
   endtask : t_stop
   task t_boot;
      pb = '0;
      pb.boot = 1'b1;
      press(pb);
      pb = '0;
      pb.run = 1'b1;
      press(pb);
      `CHK("boot without clear", 0, boot_cnt)
      t_stop();
      pb = '0;
      pb.master_clear = 1'b1;
      press(pb);
      `CHK("clear acc", 24'h000000, acc_out)
      `CHK("clear iloc", 14'h0000, iloc_out)
      pb = '0;
      pb.boot = 1'b1;
      press(pb);
      `CHK("no run yet", 1'b0, running)
      pb = '0;
      pb.run = 1'b1;
      press(pb);
      `CHK("boot with run", 1, boot_cnt)
      `CHK("boot channel", BOOT_CHANNEL, boot_chan)
      $display("test boot done");
   endtask : t_boot
   task t_rtc;
      int n, busy, pulses;
      set_sw(16'h1000);
      for (int i = 0; i < 200 && rtc_pulse !== 1'b1; i++)
      begin
         @(posedge mclk);
         #1;
      end
      n = 0;
      busy = 0;
      do
      begin
         @(posedge mclk);
         #1;
         n++;
         if (rtc_busy === 1'b1)
            busy++;
      end
      while (rtc_pulse !== 1'b1 && n < 200);
      `CHK("rtc period", PER, n)
      `CHK("rtc steal", 1'b1, busy == STL || busy == STL + 1)
      set_sw(16'h0000);
      pulses = 0;
      repeat (150)
      begin
         @(posedge mclk);
         #1;
         if (rtc_pulse === 1'b1)
            pulses++;
      end
      `CHK("rtc off", 0, pulses)
      $display("test rtc done");
   endtask : t_rtc
   initial
   begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      results();
   end
   initial
   begin
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      #1;
      `CHK("reset acc", 24'h000000, acc_out)
      `CHK("reset running", 1'b0, running)
      t_acc();
      t_iloc_run();
      t_traps();
      t_flag_skip();
      t_fault_halt();
      t_manual();
      t_stop();
      t_boot();
      t_rtc();
      results();
   end
endmodule : test_operator_panel_trap_control
